// ---- src/fsr_device.sv ----
// Flash device end: command shifter, software reset arming and execution,
// volatile state that a reset restores, and the post-reset recovery window.
// Assumes link pins are asynchronous to clk_i and sampled through two flops.
//
// The plain strobed port and the address map were decided locally.
module fsr_device
	import fsr_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	fsr_link_if.dev                   link,
	input  wire logic                 op_start_i,
	input  wire logic                 op_done_i,
	output logic                      busy_o,
	output logic                      recovering_o,
	output logic                      armed_o,
	output logic                      reset_pulse_o,
	output logic                      write_enable_latch_o,
	output logic                      suspend_flag_o,
	output logic                      four_line_command_mode_o,
	output logic [7:0]                read_param_field_o,
	output logic [7:0]                cont_read_mode_bits_o,
	output logic [2:0]                wrap_setting_bits_o,
	output logic [FSR_LOCKS-1:0]      lock_bits_o,
	output logic [7:0]                last_code_o,
	output logic                      code_valid_o
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] cs_s1_q, cs_s2_q;
	logic [4:0] dq_s1_q, dq_s2_q;
	logic       cs_prev_q, sck_prev_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cs_s1_q    <= 2'h3;
			cs_s2_q    <= 2'h3;
			dq_s1_q    <= 5'h00;
			dq_s2_q    <= 5'h00;
			cs_prev_q  <= 1'b1;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			cs_s1_q    <= {link.sck, link.cs_n};
			cs_s2_q    <= cs_s1_q;
			dq_s1_q    <= {link.quad, link.dq};
			dq_s2_q    <= dq_s1_q;
			cs_prev_q  <= cs_s2_q[0];
			sck_prev_q <= cs_s2_q[1];
		end
	end

	logic cs_n_s, sck_s, quad_s, sck_rise, frame_end;
	logic [3:0] dq_s;
	assign cs_n_s    = cs_s2_q[0];
	assign sck_s     = cs_s2_q[1];
	assign dq_s      = dq_s2_q[3:0];
	assign quad_s    = dq_s2_q[4];
	assign sck_rise  = sck_s & ~sck_prev_q & ~cs_n_s;
	assign frame_end = cs_n_s & ~cs_prev_q;

	// ****************************************************************
	// Command shifter
	// ****************************************************************
	logic [7:0] shift_q, shift_d;
	logic [3:0] nbits_q, nbits_d;

	always_comb
	begin
		shift_d = shift_q;
		nbits_d = nbits_q;
		if (cs_n_s)
			nbits_d = 4'h0;
		// The count runs past eight so that an overlong frame is refused.
		else if (sck_rise && nbits_q < 4'h9)
		begin
			if (quad_s)
			begin
				shift_d = {shift_q[3:0], dq_s};
				nbits_d = nbits_q + 4'h4;
			end
			else
			begin
				shift_d = {shift_q[6:0], dq_s[0]};
				nbits_d = nbits_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			shift_q <= 8'h00;
			nbits_q <= 4'h0;
		end
		else
		begin
			shift_q <= shift_d;
			nbits_q <= nbits_d;
		end
	end

	// ****************************************************************
	// Reset sequencing and volatile state
	// ****************************************************************
	logic       cmd_ok;
	logic       rec_q, rec_d, armed_q, armed_d, pulse_d;
	logic [FSR_CNT_W-1:0] rcnt_q, rcnt_d;
	logic       busy_d, wel_d, sus_d, qpi_d, valid_d;
	logic [7:0] par_d, mode_d, code_d;
	logic [2:0] wrap_d;
	logic [FSR_LOCKS-1:0] lock_d;

	// A code is acted on at select release only if exactly eight bits came in.
	assign cmd_ok = frame_end && (nbits_q == 4'h8) && !rec_q;

	always_comb
	begin
		rec_d   = rec_q;
		rcnt_d  = rcnt_q;
		armed_d = armed_q;
		pulse_d = 1'b0;
		busy_d  = busy_o;
		wel_d   = write_enable_latch_o;
		sus_d   = suspend_flag_o;
		qpi_d   = four_line_command_mode_o;
		par_d   = read_param_field_o;
		mode_d  = cont_read_mode_bits_o;
		wrap_d  = wrap_setting_bits_o;
		lock_d  = lock_bits_o;
		code_d  = last_code_o;
		valid_d = 1'b0;
		// A start in the same cycle as a done wins.
		if (op_done_i)
			busy_d = 1'b0;
		if (op_start_i)
			busy_d = 1'b1;
		if (rec_q)
		begin
			if (rcnt_q == FSR_CNT_W'(FSR_RECOVER_CYC - 1))
				rec_d = 1'b0;
			rcnt_d = rcnt_q + FSR_CNT_W'(1);
		end
		if (cmd_ok)
		begin
			code_d  = shift_q;
			valid_d = 1'b1;
			armed_d = 1'b0;
			if (shift_q == FSR_CMD_ARM)
				armed_d = 1'b1;
			else if (shift_q == FSR_CMD_EXECUTE && armed_q)
			begin
				pulse_d = 1'b1;
				rec_d   = 1'b1;
				rcnt_d  = '0;
				busy_d  = 1'b0;
				wel_d   = 1'b0;
				sus_d   = 1'b0;
				qpi_d   = 1'b0;
				par_d   = FSR_PAR_RST;
				mode_d  = FSR_MODE_RST;
				wrap_d  = FSR_WRAP_RST;
				lock_d  = '1;
			end
			else
			begin
				unique case (shift_q)
					FSR_CMD_WREN:    wel_d = 1'b1;
					FSR_CMD_QPI_ON:  qpi_d = 1'b1;
					FSR_CMD_QPI_OFF: qpi_d = 1'b0;
					FSR_CMD_SET_PAR: par_d = par_d;
					FSR_CMD_GLOCK:
					begin
						if (wel_d)
							lock_d = '1;
						wel_d = 1'b0;
					end
					FSR_CMD_GUNLOCK:
					begin
						if (wel_d)
							lock_d = '0;
						wel_d = 1'b0;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rec_q                    <= 1'b0;
			rcnt_q                   <= '0;
			armed_q                  <= 1'b0;
			reset_pulse_o            <= 1'b0;
			busy_o                   <= 1'b0;
			write_enable_latch_o     <= 1'b0;
			suspend_flag_o           <= 1'b0;
			four_line_command_mode_o <= 1'b0;
			read_param_field_o       <= FSR_PAR_RST;
			cont_read_mode_bits_o    <= FSR_MODE_RST;
			wrap_setting_bits_o      <= FSR_WRAP_RST;
			lock_bits_o              <= '1;
			last_code_o              <= 8'h00;
			code_valid_o             <= 1'b0;
		end
		else
		begin
			rec_q                    <= rec_d;
			rcnt_q                   <= rcnt_d;
			armed_q                  <= armed_d;
			reset_pulse_o            <= pulse_d;
			busy_o                   <= busy_d;
			write_enable_latch_o     <= wel_d;
			suspend_flag_o           <= sus_d;
			four_line_command_mode_o <= qpi_d;
			read_param_field_o       <= par_d;
			cont_read_mode_bits_o    <= mode_d;
			wrap_setting_bits_o      <= wrap_d;
			lock_bits_o              <= lock_d;
			last_code_o              <= code_d;
			code_valid_o             <= valid_d;
		end
	end

	// Registered copies of internal state for the user side.
	logic rec_o_q, armed_o_q;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rec_o_q   <= 1'b0;
			armed_o_q <= 1'b0;
		end
		else
		begin
			rec_o_q   <= rec_d;
			armed_o_q <= armed_d;
		end
	end
	assign recovering_o = rec_o_q;
	assign armed_o      = armed_o_q;

endmodule

// ---- src/fsr_pkg.sv ----
// Shared constants for the flash software reset sequencer: instruction codes,
// link widths and timing counts derived from the 20 MHz system clock.
// Assumes both ends run on the same clk_i and rst_i.
package fsr_pkg;

	// ****************************************************************
	// Instruction codes
	// ****************************************************************
	localparam logic [7:0] FSR_CMD_ARM     = 8'h66;
	localparam logic [7:0] FSR_CMD_EXECUTE = 8'h99;
	localparam logic [7:0] FSR_CMD_WREN    = 8'h06;
	localparam logic [7:0] FSR_CMD_QPI_ON  = 8'h38;
	localparam logic [7:0] FSR_CMD_QPI_OFF = 8'hFF;
	localparam logic [7:0] FSR_CMD_SET_PAR = 8'hC0;
	localparam logic [7:0] FSR_CMD_GLOCK   = 8'h7E;
	localparam logic [7:0] FSR_CMD_GUNLOCK = 8'h98;

	// ****************************************************************
	// Geometry and reset values
	// ****************************************************************
	localparam int unsigned FSR_CODE_W  = 8;
	localparam int unsigned FSR_LOCKS   = 16;
	localparam logic [7:0]  FSR_PAR_RST = 8'h00;
	localparam logic [7:0]  FSR_MODE_RST = 8'h00;
	localparam logic [2:0]  FSR_WRAP_RST = 3'h7;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned FSR_CLK_HZ      = 20000000;
	localparam int unsigned FSR_RECOVER_US  = 30;
	localparam int unsigned FSR_SELECT_US   = 20;
	localparam int unsigned FSR_WRITE_MS    = 5;
	// Recovery is a longest time (rounded down); the select wait rounds up, the write wait rounds down.
	localparam int unsigned FSR_RECOVER_CYC = (FSR_RECOVER_US * (FSR_CLK_HZ / 1000000));
	localparam int unsigned FSR_SELECT_CYC  = (FSR_SELECT_US * FSR_CLK_HZ + 999999) / 1000000;
	localparam int unsigned FSR_WRITE_CYC   = (FSR_WRITE_MS * (FSR_CLK_HZ / 1000));
	// Serial clock half period in system clocks for the host's divider.
	localparam int unsigned FSR_SCK_HALF    = 2;
	localparam int unsigned FSR_CNT_W       = 20;

endpackage

// ---- src/fsr_link_if.sv ----
// Serial command link between the host controller and the flash device.
// Chip select low frames each instruction; data changes on falling and is
// sampled on rising serial clock. Four data lines are carried for the
// four-line command mode; line 0 is the single-line data input.
interface fsr_link_if;
	logic       cs_n;
	logic       sck;
	logic [3:0] dq;
	logic       quad;

	modport host
	(
		output cs_n,
		output sck,
		output dq,
		output quad
	);

	modport dev
	(
		input cs_n,
		input sck,
		input dq,
		input quad
	);
endinterface

// ---- src/fsr_host.sv ----
// Host controller end: power-up waits, then sends single instruction codes on
// the serial link, each in its own select frame, and the reset pair on request.
// Software drives it through a small register port; read data one cycle later.
module fsr_host
	import fsr_pkg::*;
#(
	parameter int unsigned SELECT_CYC  = FSR_SELECT_CYC,
	parameter int unsigned WRITE_CYC   = FSR_WRITE_CYC,
	parameter int unsigned RECOVER_CYC = FSR_RECOVER_CYC
)
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	fsr_link_if.host        link,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o
);

	// Register map: 0 command code (write sends it), 1 control (bit0 quad,
	// bit1 send reset pair), 2 status (bit0 busy, bit1 select ok, bit2 write ok).
	localparam logic [1:0] REG_CMD  = 2'h0;
	localparam logic [1:0] REG_CTRL = 2'h1;
	localparam logic [1:0] REG_STAT = 2'h2;

	typedef enum logic [2:0]
	{
		S_POWER = 3'b000,
		S_IDLE  = 3'b001,
		S_SHIFT = 3'b010,
		S_GAP   = 3'b011,
		S_WAIT  = 3'b100
	} fsr_state_t;

	fsr_state_t state_q, state_d;
	logic [FSR_CNT_W-1:0] pcnt_q, pcnt_d, tcnt_q, tcnt_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bits_q, bits_d;
	logic [1:0] div_q, div_d;
	logic       quad_q, quad_d, pair_q, pair_d, wok_q, wok_d;
	logic       cs_q, cs_d, sck_q, sck_d;
	logic [3:0] dq_q, dq_d;
	logic [7:0] rdata_d;
	logic       last_exec_q, last_exec_d;

	always_comb
	begin
		state_d = state_q;
		pcnt_d  = pcnt_q;
		tcnt_d  = tcnt_q;
		sh_d    = sh_q;
		bits_d  = bits_q;
		div_d   = div_q;
		quad_d  = quad_q;
		pair_d  = pair_q;
		wok_d   = wok_q;
		cs_d    = cs_q;
		sck_d   = sck_q;
		dq_d    = dq_q;
		rdata_d = 8'h00;
		if (pcnt_q != FSR_CNT_W'(WRITE_CYC))
			pcnt_d = pcnt_q + FSR_CNT_W'(1);
		else
			wok_d = 1'b1;
		if (rd_i)
			unique case (addr_i)
				REG_CTRL: rdata_d = {6'h00, pair_q, quad_q};
				REG_STAT: rdata_d = {5'h00, wok_q, (state_q != S_POWER), (state_q != S_IDLE)};
				default:  rdata_d = sh_q;
			endcase
		if (wr_i && addr_i == REG_CTRL && state_q == S_IDLE)
		begin
			quad_d = wdata_i[0];
			if (wdata_i[1])
			begin
				pair_d  = 1'b1;
				sh_d    = FSR_CMD_ARM;
				state_d = S_SHIFT;
			end
		end
		unique case (state_q)
			S_POWER:
				if (pcnt_q >= FSR_CNT_W'(SELECT_CYC))
					state_d = S_IDLE;
			S_IDLE:
				if (wr_i && addr_i == REG_CMD)
				begin
					sh_d    = wdata_i;
					state_d = S_SHIFT;
				end
			S_SHIFT:
			begin
				cs_d  = 1'b0;
				div_d = div_q + 2'h1;
				if (div_q == 2'(FSR_SCK_HALF - 1))
				begin
					div_d = 2'h0;
					if (sck_q)
					begin
						// Data moves on the falling edge so it is settled well before the next rise.
						sck_d = 1'b0;
						sh_d  = quad_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
						dq_d  = quad_q ? sh_q[3:0] : {3'h0, sh_q[6]};
						if (bits_q == (quad_q ? 4'h2 : 4'h8))
						begin
							cs_d    = 1'b1;
							bits_d  = 4'h0;
							tcnt_d  = '0;
							state_d = S_GAP;
						end
					end
					else if (cs_q == 1'b0)
					begin
						sck_d  = 1'b1;
						bits_d = bits_q + 4'h1;
					end
				end
				if (cs_q && state_d == S_SHIFT)
					dq_d = quad_q ? sh_q[7:4] : {3'h0, sh_q[7]};
			end
			S_GAP:
			begin
				tcnt_d = tcnt_q + FSR_CNT_W'(1);
				if (tcnt_q == FSR_CNT_W'(3))
				begin
					if (pair_q && sh_q == 8'h00 && bits_q == 4'h0)
					begin
						pair_d  = 1'b0;
						sh_d    = FSR_CMD_EXECUTE;
						bits_d  = 4'h0;
						tcnt_d  = '0;
						state_d = S_WAIT;
					end
					else
						state_d = S_IDLE;
				end
			end
			S_WAIT:
			begin
				// Execute code goes out first, then the recovery wait.
				if (sh_q == FSR_CMD_EXECUTE)
					state_d = S_SHIFT;
				else
				begin
					tcnt_d = tcnt_q + FSR_CNT_W'(1);
					if (tcnt_q == FSR_CNT_W'(RECOVER_CYC))
						state_d = S_IDLE;
				end
			end
			default: state_d = S_IDLE;
		endcase
		// After the reset pair's execute frame the host sits out the device's recovery time.
		if (state_q == S_GAP && tcnt_q == FSR_CNT_W'(3) && !pair_q && last_exec_q)
		begin
			tcnt_d  = '0;
			state_d = S_WAIT;
		end
	end

	// Remembers that the frame just finished carried the reset pair's execute code.
	always_comb
	begin
		last_exec_d = last_exec_q;
		if (state_q == S_WAIT && sh_q == FSR_CMD_EXECUTE)
			last_exec_d = 1'b1;
		else if (state_q == S_WAIT)
			last_exec_d = 1'b0;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q     <= S_POWER;
			pcnt_q      <= '0;
			tcnt_q      <= '0;
			sh_q        <= 8'h00;
			bits_q      <= 4'h0;
			div_q       <= 2'h0;
			quad_q      <= 1'b0;
			pair_q      <= 1'b0;
			wok_q       <= 1'b0;
			cs_q        <= 1'b1;
			sck_q       <= 1'b0;
			dq_q        <= 4'h0;
			rdata_o     <= 8'h00;
			last_exec_q <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			pcnt_q      <= pcnt_d;
			tcnt_q      <= tcnt_d;
			sh_q        <= sh_d;
			bits_q      <= bits_d;
			div_q       <= div_d;
			quad_q      <= quad_d;
			pair_q      <= pair_d;
			wok_q       <= wok_d;
			cs_q        <= cs_d;
			sck_q       <= sck_d;
			dq_q        <= dq_d;
			rdata_o     <= rdata_d;
			last_exec_q <= last_exec_d;
		end
	end

	assign link.cs_n = cs_q;
	assign link.sck  = sck_q;
	assign link.dq   = dq_q;
	assign link.quad = quad_q;

endmodule

// ---- verification/fsr_props.sv ----
// Assertion checker for the reset sequencer: link idle level and the
// device's arming, reset, default restore and recovery behaviour.
// Assumes it sits beside the link interface in the bench top.
module fsr_props
	import fsr_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 cs_n,
	input wire logic                 sck,
	input wire logic                 busy_o,
	input wire logic                 recovering_o,
	input wire logic                 armed_o,
	input wire logic                 reset_pulse_o,
	input wire logic                 write_enable_latch_o,
	input wire logic                 suspend_flag_o,
	input wire logic                 four_line_command_mode_o,
	input wire logic [7:0]           read_param_field_o,
	input wire logic [7:0]           cont_read_mode_bits_o,
	input wire logic [2:0]           wrap_setting_bits_o,
	input wire logic [FSR_LOCKS-1:0] lock_bits_o,
	input wire logic [7:0]           last_code_o,
	input wire logic                 code_valid_o
);
	// ****************************************************************
	// Recovery length counter and properties
	// ****************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [9:0] rec_q;
	logic [9:0] rec_d;
	always_comb rec_d = recovering_o ? rec_q + 10'h001 : 10'h000;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rec_q <= 10'h000;
		else
			rec_q <= rec_d;
	end
	sequence s_accept;
		reset_pulse_o;
	endsequence
	sequence s_defaults;
		!write_enable_latch_o && !suspend_flag_o && !four_line_command_mode_o && !busy_o && !armed_o
			&& read_param_field_o == FSR_PAR_RST && cont_read_mode_bits_o == FSR_MODE_RST
			&& wrap_setting_bits_o == FSR_WRAP_RST;
	endsequence
	a_arm_before_reset: assert property (s_accept |-> $past(armed_o)) else $error("reset without arming");
	a_reset_defaults: assert property (s_accept |-> ##[0:1] s_defaults) else $error("defaults lost");
	a_locks_all_set: assert property (s_accept |-> ##[0:1] lock_bits_o == '1) else $error("locks open");
	a_recover_entry: assert property (s_accept |=> recovering_o [*8]) else $error("no recovery");
	a_recover_length: assert property ($fell(recovering_o) |-> rec_q == 10'(FSR_RECOVER_CYC))
		else $error("bad recovery");
	a_quiet_recovery: assert property (recovering_o && $past(recovering_o) |-> !code_valid_o)
		else $error("code taken in recovery");
	a_other_disarms: assert property (code_valid_o && last_code_o != FSR_CMD_ARM |-> ##[0:1] !armed_o)
		else $error("still armed");
	a_arm_sets: assert property (code_valid_o && last_code_o == FSR_CMD_ARM |-> ##[0:1] armed_o)
		else $error("not armed");
	a_sck_idle: assert property (cs_n |-> !sck) else $error("clock outside frame");
	a_busy_cleared: assert property (s_accept |=> !busy_o [*2]) else $error("work not aborted");
endmodule

// ---- verification/flash_software_reset_sequencer_tb_top.sv ----
// Bench: host and device joined on one link, model compared at each step;
// a second device takes raw frames straight from the bench, one well-formed and one overlong.
// Assumes the package and link interface are compiled first.
module flash_software_reset_sequencer_tb_top
	import fsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************************************
	// Signals, instances and monitors
	// ****************************************************************
	logic                 clk_i, rst_i, wr_i, rd_i, op_start_i, op_done_i;
	logic [1:0]           addr_i;
	logic [7:0]           wdata_i, rdata_o, last_code_o, rd_val, code;
	logic                 busy_o, recovering_o, armed_o, reset_pulse_o, write_enable_latch_o, suspend_flag_o;
	logic                 four_line_command_mode_o, code_valid_o, armed_b, pulse_b, valid_b;
	logic [7:0]           read_param_field_o, cont_read_mode_bits_o;
	logic [2:0]           wrap_setting_bits_o;
	logic [FSR_LOCKS-1:0] lock_bits_o, lock_m;
	logic [15:0]          sh;
	int                   num_errors, cmp_count, n_rst, nb_code, nb_rst, cyc, nb, seed;
	int                   wel_m, arm_m, qpi_m, rec_m, busy_m, quad_m, rst_m;
	int                   wire_q[$];
	fsr_link_if link ();
	fsr_link_if link_b ();
	fsr_host #(.SELECT_CYC(40), .WRITE_CYC(50), .RECOVER_CYC(20)) fsr_host_inst (.clk_i, .rst_i, .link(link),
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
	fsr_device fsr_device_inst (.clk_i, .rst_i, .link(link), .op_start_i, .op_done_i, .busy_o, .recovering_o,
		.armed_o, .reset_pulse_o, .write_enable_latch_o, .suspend_flag_o, .four_line_command_mode_o,
		.read_param_field_o, .cont_read_mode_bits_o, .wrap_setting_bits_o, .lock_bits_o, .last_code_o, .code_valid_o);
	fsr_props fsr_props_inst (.clk_i, .rst_i, .cs_n(link.cs_n), .sck(link.sck), .busy_o, .recovering_o,
		.armed_o, .reset_pulse_o, .write_enable_latch_o, .suspend_flag_o, .four_line_command_mode_o,
		.read_param_field_o, .cont_read_mode_bits_o, .wrap_setting_bits_o, .lock_bits_o, .last_code_o, .code_valid_o);
	fsr_device fsr_device_inst_b (.clk_i, .rst_i, .link(link_b), .op_start_i(1'b0), .op_done_i(1'b0), .busy_o(),
		.recovering_o(), .armed_o(armed_b), .reset_pulse_o(pulse_b), .write_enable_latch_o(), .suspend_flag_o(),
		.four_line_command_mode_o(), .read_param_field_o(), .cont_read_mode_bits_o(), .wrap_setting_bits_o(),
		.lock_bits_o(), .last_code_o(), .code_valid_o(valid_b));
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (reset_pulse_o === 1'b1) n_rst++;
		if (pulse_b === 1'b1) nb_rst++;
		if (valid_b === 1'b1) nb_code++;
		if (cyc == 20000)
		begin
			num_errors++;
			results();
		end
	end
	always @(negedge link.cs_n) nb = 0;
	always @(posedge link.sck)
	begin
		if (link.cs_n === 1'b0) sh = link.quad ? {sh[11:0], link.dq} : {sh[14:0], link.dq[0]};
		nb++;
	end
	always @(posedge link.cs_n) wire_q.push_back(nb * 256 + sh[7:0]);
	// ****************************************************************
	// Tasks and main sequence
	// ****************************************************************
	task automatic results();
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_i);
		{addr_i, rd_i} <= {a, 1'b1};
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 300; i++)
		begin
			reg_rd(2'h2, rd_val);
			if (rd_val[0] === 1'b0) break;
		end
		check("idle", 20'(rd_val[0]), 20'h0);
		repeat (6) @(posedge clk_i);
	endtask
	task automatic apply(input logic [7:0] c);
		if (rec_m == 0)
		begin
			if (arm_m == 1 && c == FSR_CMD_EXECUTE)
			begin
				{wel_m, qpi_m, busy_m, rec_m} = {32'd0, 32'd0, 32'd0, 32'd1};
				rst_m++;
				lock_m = '1;
			end
			if (c == FSR_CMD_WREN) wel_m = 1;
			if (c == FSR_CMD_QPI_ON) qpi_m = 1;
			if (c == FSR_CMD_QPI_OFF) qpi_m = 0;
			if (wel_m == 1 && c inside {FSR_CMD_GLOCK, FSR_CMD_GUNLOCK}) lock_m = {FSR_LOCKS{c == FSR_CMD_GLOCK}};
			if (c inside {FSR_CMD_GLOCK, FSR_CMD_GUNLOCK}) wel_m = 0;
			arm_m = int'(c == FSR_CMD_ARM);
		end
	endtask
	task automatic frame(input logic [7:0] c);
		check("frame", 20'(wire_q.pop_front()), 20'((quad_m == 1 ? 512 : 2048) + c));
	endtask
	task automatic check_dev();
		@(negedge clk_i);
		check("wel", 20'(write_enable_latch_o), 20'(wel_m[0]));
		check("armed", 20'(armed_o), 20'(arm_m[0]));
		check("quad", 20'(four_line_command_mode_o), 20'(qpi_m[0]));
		check("busy", 20'(busy_o), 20'(busy_m[0]));
		check("recovering", 20'(recovering_o), 20'(rec_m[0]));
		check("locks", 20'(lock_bits_o), 20'(lock_m));
		check("resets", 20'(n_rst), 20'(rst_m));
		check("volatile", {suspend_flag_o, wrap_setting_bits_o, read_param_field_o, cont_read_mode_bits_o},
			{1'b0, FSR_WRAP_RST, FSR_PAR_RST, FSR_MODE_RST});
	endtask
	task automatic send(input logic [7:0] c);
		apply(c);
		reg_wr(2'h0, c);
		wait_idle();
		frame(c);
	endtask
	task automatic op(input logic s);
		@(posedge clk_i);
		{op_start_i, op_done_i} <= {s, !s};
		@(posedge clk_i);
		{op_start_i, op_done_i} <= 2'h0;
		busy_m = int'(s);
		check_dev();
	endtask
	task automatic do_reset(input logic q);
		apply(FSR_CMD_ARM);
		apply(FSR_CMD_EXECUTE);
		quad_m = int'(q);
		reg_wr(2'h1, {6'h00, 1'b1, q});
		wait_idle();
		frame(FSR_CMD_ARM);
		frame(FSR_CMD_EXECUTE);
		check_dev();
		send(FSR_CMD_WREN);
		check_dev();
		for (int i = 0; i < 800 && recovering_o !== 1'b0; i++) @(posedge clk_i);
		rec_m = 0;
		check_dev();
	endtask
	task automatic raw(input logic [15:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge clk_i);
			{link_b.cs_n, link_b.sck, link_b.dq} <= {2'h0, 3'h0, v[i]};
			repeat (2) @(posedge clk_i);
			link_b.sck <= 1'b1;
			@(posedge clk_i);
		end
		@(posedge clk_i);
		link_b.sck <= 1'b0;
		repeat (2) @(posedge clk_i);
		{link_b.cs_n, link_b.dq} <= {1'b1, ~link_b.dq};
		repeat (12) @(posedge clk_i);
	endtask
	initial
	begin
		{rst_i, wr_i, rd_i, op_start_i, op_done_i, addr_i, wdata_i} = {5'h10, 10'h000};
		{link_b.cs_n, link_b.sck, link_b.dq, link_b.quad} = 7'h40;
		lock_m = '1;
		seed = $urandom(32'hE721);
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wire_q.delete();
		check_dev();
		reg_wr(2'h0, FSR_CMD_WREN);
		reg_rd(2'h2, rd_val);
		check("status", 20'(rd_val[2:0]), 20'h1);
		repeat (10) @(posedge clk_i);
		check("early", 20'(wire_q.size()), 20'h0);
		for (int i = 0; i < 100 && rd_val[1] !== 1'b1; i++) reg_rd(2'h2, rd_val);
		check("select", 20'(cyc > 45 && rd_val[1] === 1'b1), 20'h1);
		for (int i = 0; i < 100 && rd_val[2] !== 1'b1; i++) reg_rd(2'h2, rd_val);
		check("write ok", 20'(cyc > 55 && rd_val[2] === 1'b1), 20'h1);
		send(FSR_CMD_WREN);
		send(FSR_CMD_GUNLOCK);
		send(FSR_CMD_GLOCK);
		send(FSR_CMD_WREN);
		check_dev();
		for (int i = 0; i < 4; i++)
		begin
			code = 8'($urandom_range(255));
			if (code inside {FSR_CMD_ARM, FSR_CMD_EXECUTE, FSR_CMD_QPI_ON, FSR_CMD_QPI_OFF, FSR_CMD_GLOCK,
				FSR_CMD_GUNLOCK}) code = FSR_CMD_SET_PAR;
			check("quiet", 20'({busy_o, suspend_flag_o}), 20'h0);
			send(FSR_CMD_ARM);
			check_dev();
			send(code);
			send(FSR_CMD_EXECUTE);
			check_dev();
		end
		send(FSR_CMD_QPI_ON);
		op(1'b1);
		send(FSR_CMD_QPI_OFF);
		op(1'b0);
		send(FSR_CMD_QPI_ON);
		op(1'b1);
		do_reset(1'b1);
		reg_wr(2'h1, 8'h00);
		quad_m = 0;
		op(1'b1);
		do_reset(1'b0);
		raw(16'h0066, 8);
		check("armed b", 20'(armed_b), 20'h1);
		raw({FSR_CMD_ARM, FSR_CMD_EXECUTE}, 16);
		check("codes b", 20'(nb_code), 20'h1);
		check("resets b", 20'(nb_rst), 20'h0);
		results();
	end
endmodule
